/* File: sss_sram.v */
// synchronous flow-through sram: select, write decode, high-z, sleep
`timescale 1ns/1ps
`include "sss_regs.vh"
module sss_sram #(
   parameter ADDR_W = `SSS_ADDR_W,
   parameter DATA_W = `SSS_DATA_W,
   parameter LANES  = `SSS_LANES,
   parameter DEPTH  = `SSS_DEPTH
) (
   // clock and reset
   input  wire              sys_clk,
   input  wire              reset,
   // chip enables
   input  wire              chip_enable_a_n,
   input  wire              chip_enable_b,
   input  wire              chip_enable_c_n,
   // address strobes and address
   input  wire              processor_address_strobe_n,
   input  wire              controller_address_strobe_n,
   input  wire [ADDR_W-1:0] addr,
   // write controls
   input  wire              global_write_n,
   input  wire              byte_write_gate_n,
   input  wire [LANES-1:0]  byte_lane_write_n,
   // output enable and sleep
   input  wire              output_enable_n,
   input  wire              sleep_pin,
   // data bus
   input  wire [DATA_W-1:0] data_in,
   output wire [DATA_W-1:0] data_out,
   output wire              data_oe_n,
   // status
   output wire              in_sleep
);
   // state and drive registers
   reg  [3:0]        state;
   reg  [3:0]        next_state;
   reg               drive;
   // select terms
   wire              sel_a;
   wire              sel_b;
   wire              sel_c;
   wire              selected;
   // strobe terms
   wire              strobe_p;
   wire              strobe_c;
   wire              strobe;
   // sleep terms
   wire              sleep_state;
   wire              awake;
   // write decode terms
   wire              gw_full;
   wire              lane_full;
   wire              full_write;
   wire [LANES-1:0]  lane_req;
   wire [LANES-1:0]  lane_we;
   wire              any_write;
   // accepted cycle kinds
   wire              cycle_ok;
   wire              start_write;
   wire              start_read;
   wire              desel_strobe;
   // bus gating terms
   wire              read_cycle;
   wire              bus_on;
   wire [DATA_W-1:0] rdata;

   // each enable term alone; all three must hold for a select
   // any one term false deselects, whatever the other two show
   assign sel_a    = ~chip_enable_a_n;
   assign sel_b    = chip_enable_b;
   assign sel_c    = ~chip_enable_c_n;
   assign selected = sel_a & sel_b & sel_c;

   // either strobe opens an access when selected
   assign strobe_p = ~processor_address_strobe_n;
   assign strobe_c = ~controller_address_strobe_n;
   assign strobe   = strobe_p | strobe_c;

   // sleep pin or sleep state blocks every synchronous input
   // the pin acts at once, before the state register has caught up
   assign sleep_state = (state == `SSS_ST_SLEEP);
   assign awake       = ~sleep_pin & ~sleep_state;

   // full write: global write low, or gate low with every lane low
   assign gw_full    = ~global_write_n;
   assign lane_full  = ~byte_write_gate_n & ~(|byte_lane_write_n);
   assign full_write = gw_full | lane_full;

   // a cycle counts only while selected and awake
   assign cycle_ok = awake & selected;

   // per-lane write enable: full write, or gate low with this lane low
   // gating by cycle_ok keeps contents safe in sleep and deselect
   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1) begin : lane
         assign lane_req[g] = full_write
                              | (~byte_write_gate_n
                                 & ~byte_lane_write_n[g]);
         assign lane_we[g]  = cycle_ok & lane_req[g];
      end
   endgenerate
   assign any_write = |lane_we;

   // processor strobe always starts a read; write pins still write the array through lane_we
   // writes need no strobe: burst continuation is simplified here
   assign start_write  = any_write & ~strobe_p;
   assign start_read   = cycle_ok & strobe & ~start_write;
   // a strobe while deselected ends a standing read
   assign desel_strobe = strobe & ~selected;

   // access state: idle, read, write, sleep
   // sleep request wins over any access in the same cycle
   always @* begin
      next_state = state;
      case (state)
         `SSS_ST_IDLE: begin
            // sleep first, then write, then read
            if (sleep_pin) begin
               next_state = `SSS_ST_SLEEP;
            end else if (start_write) begin
               next_state = `SSS_ST_WRITE;
            end else if (start_read) begin
               next_state = `SSS_ST_READ;
            end
         end
         `SSS_ST_READ: begin
            // a read stands until write, deselect strobe or sleep
            if (sleep_pin) begin
               next_state = `SSS_ST_SLEEP;
            end else if (start_write) begin
               next_state = `SSS_ST_WRITE;
            end else if (start_read) begin
               next_state = `SSS_ST_READ;
            end else if (desel_strobe) begin
               next_state = `SSS_ST_IDLE;
            end
         end
         `SSS_ST_WRITE: begin
            // bus stays off here until a new strobed read
            if (sleep_pin) begin
               next_state = `SSS_ST_SLEEP;
            end else if (start_write) begin
               next_state = `SSS_ST_WRITE;
            end else if (start_read) begin
               next_state = `SSS_ST_READ;
            end else if (desel_strobe) begin
               next_state = `SSS_ST_IDLE;
            end
         end
         `SSS_ST_SLEEP: begin
            // leave only to idle, never straight into a read
            if (!sleep_pin) begin
               next_state = `SSS_ST_IDLE;
            end
         end
         default: next_state = `SSS_ST_IDLE;
      endcase
   end

   // state register
   always @(posedge sys_clk) begin
      if (reset) begin
         state <= `SSS_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // only a read cycle may turn the bus on at the next edge
   assign read_cycle = (next_state == `SSS_ST_READ);

   // output drive only after a strobed read, never after write or sleep
   always @(posedge sys_clk) begin
      if (reset) begin
         drive <= 1'b0;
      end else begin
         drive <= read_cycle;
      end
   end

   // storage array, written only through the gated lane enables
   sss_array #(
      .ADDR_W (ADDR_W),
      .DATA_W (DATA_W),
      .LANES  (LANES),
      .DEPTH  (DEPTH)
   ) u_array (
      .sys_clk (sys_clk),
      .addr    (addr),
      .lane_we (lane_we),
      .wdata   (data_in),
      .rdata   (rdata)
   );

   // bus gate: registered drive, output enable and sleep pin
   // the sleep pin cuts the bus at once, not one edge later
   assign bus_on    = drive & ~output_enable_n & ~sleep_pin;
   assign data_oe_n = ~bus_on;
   assign data_out  = rdata;
   assign in_sleep  = sleep_state;
endmodule // sss_sram

/* File: sss_regs.vh */
// constants for the synchronous select/write/sleep sram block
`ifndef SSS_REGS_VH
`define SSS_REGS_VH
`define SSS_ADDR_W    19
`define SSS_DATA_W    18
`define SSS_LANES     2
`define SSS_DEPTH     524288
`define SSS_ST_IDLE   4'h1
`define SSS_ST_READ   4'h2
`define SSS_ST_WRITE  4'h4
`define SSS_ST_SLEEP  4'h8
`endif

/* File: sss_array.v */
// storage array with per-lane write enables
`timescale 1ns/1ps
`include "sss_regs.vh"
module sss_array #(
   parameter ADDR_W = `SSS_ADDR_W,
   parameter DATA_W = `SSS_DATA_W,
   parameter LANES  = `SSS_LANES,
   parameter DEPTH  = `SSS_DEPTH
) (
   // clock
   input  wire              sys_clk,
   // access
   input  wire [ADDR_W-1:0] addr,
   input  wire [LANES-1:0]  lane_we,
   input  wire [DATA_W-1:0] wdata,
   output wire [DATA_W-1:0] rdata
);
   localparam LW = DATA_W / LANES;
   genvar g;
   // each lane owns its storage and read register, so one driver each
   generate
      for (g = 0; g < LANES; g = g + 1) begin : lane
         reg [LW-1:0] mem [0:DEPTH-1];
         reg [LW-1:0] q;
         always @(posedge sys_clk) begin
            if (lane_we[g]) begin
               mem[addr] <= wdata[g*LW +: LW];
            end
            q <= mem[addr]; // registered read
         end
         assign rdata[g*LW +: LW] = q;
      end
   endgenerate
endmodule // sss_array

/* File: sss_chk_asserts.sv */
// checker for select, write, high-z and sleep behaviour
`timescale 1ns/1ps
module sss_chk (
   // clock, reset, controls
   input wire sys_clk,
   input wire reset,
   input wire chip_enable_a_n,
   input wire chip_enable_b,
   input wire chip_enable_c_n,
   input wire processor_address_strobe_n,
   input wire controller_address_strobe_n,
   input wire global_write_n,
   input wire output_enable_n,
   input wire sleep_pin,
   // status
   input wire data_oe_n,
   input wire in_sleep
);
   // decoded select, strobe and accepted cycle
   wire sel = !chip_enable_a_n & chip_enable_b & !chip_enable_c_n;
   wire ps = !processor_address_strobe_n;
   wire go = sel & !sleep_pin & !in_sleep;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   read_drive_a: assert property (
      go && ps |=> output_enable_n || !data_oe_n) else $error("no drive");
   desel_a: assert property (
      !sel && ps |=> data_oe_n) else $error("deselect drove");
   write_hiz_a: assert property (
      go && !ps && !global_write_n |=> data_oe_n) else $error("write drove");
   hold_hiz_a: assert property (
      $fell(data_oe_n) && !$past(output_enable_n) |->
      !$past(processor_address_strobe_n) ||
      !$past(controller_address_strobe_n)) else $error("drive no strobe");
   wake_hiz_a: assert property (
      $fell(in_sleep) |-> data_oe_n) else $error("wake drove");
   sleep_quiet_a: assert property (
      in_sleep |-> data_oe_n) else $error("sleep drove");
   cover property (go && ps);
   cover property (go && !global_write_n);
   cover property ($fell(in_sleep));
endmodule // sss_chk
bind sss_sram sss_chk u_chk (.*);

/* File: sss_ctl.sv */
// controller model driving the sram inputs
`timescale 1ns/1ps
module sss_ctl (
   input  wire        sys_clk,
   output reg  [2:0]  ce,
   output reg  [5:0]  ctl,
   output reg  [7:0]  addr,
   output reg  [17:0] data_in,
   output reg         sleep_pin
);
   // one cycle of control, then deselected idle with data inverted
   task acc(input [2:0] c, input [5:0] k, input [7:0] a, input [17:0] d);
      begin
         @(negedge sys_clk);
         ce <= c;
         ctl <= k;
         addr <= a;
         data_in <= d;
         @(negedge sys_clk);
         ce <= 3'h5;
         ctl <= 6'h3f;
         data_in <= ~d;
      end
   endtask
   // sleep pin moves only while idle and deselected
   task zz(input s);
      begin
         @(negedge sys_clk);
         sleep_pin <= s;
      end
   endtask
   initial {ce, ctl, addr, data_in, sleep_pin} = {3'h5, 6'h3f, 27'h0};
endmodule // sss_ctl

/* File: sss_sram_tb.sv */
// testbench for select, write, high-z and sleep
`timescale 1ns/1ps
module sss_sram_tb;
   reg sys_clk, reset;
   wire [2:0] ce;
   wire [5:0] ctl;
   wire [7:0] addr;
   wire [17:0] di, data_out;
   wire zz, data_oe_n, in_sleep;
   integer fail_count, n_checks;
   reg oe_n;
   sss_ctl u_ctl (.sys_clk(sys_clk), .ce(ce), .ctl(ctl), .addr(addr),
      .data_in(di), .sleep_pin(zz));
   sss_sram #(.ADDR_W(8), .DEPTH(256)) u_dut (.sys_clk(sys_clk),
      .reset(reset), .chip_enable_a_n(ce[2]), .chip_enable_b(ce[1]),
      .chip_enable_c_n(ce[0]), .processor_address_strobe_n(ctl[5]),
      .controller_address_strobe_n(ctl[4]), .addr(addr),
      .global_write_n(ctl[3]), .byte_write_gate_n(ctl[2]),
      .byte_lane_write_n(ctl[1:0]), .output_enable_n(oe_n),
      .sleep_pin(zz), .data_in(di), .data_out(data_out),
      .data_oe_n(data_oe_n), .in_sleep(in_sleep));
   // compare and count
   task chk(input [23:0] nm, input [18:0] s, input [18:0] e);
      begin
         n_checks = n_checks + 1;
         if (s !== e) begin
            fail_count = fail_count + 1;
            $display("MISMATCH %0s exp %h seen %h", nm, e, s);
         end
      end
   endtask
   // read address a through strobe k, expect bus driven with e
   task rd(input [5:0] k, input [7:0] a, input [17:0] e);
      begin
         u_ctl.acc(3'h2, k, a, 18'h0);
         chk("rd", {data_oe_n, data_out}, {1'b0, e});
      end
   endtask
   task t_rw;
      begin
         u_ctl.acc(3'h2, 6'h27, 8'h00, 18'h2aa55);
         chk("wr", {data_oe_n, 18'h0}, {1'b1, 18'h0});
         u_ctl.acc(3'h2, 6'h38, 8'hff, 18'h15ac3);
         rd(6'h1f, 8'h00, 18'h2aa55);
         rd(6'h2f, 8'hff, 18'h15ac3);
         u_ctl.acc(3'h6, 6'h27, 8'h00, 18'h3ffff);
         u_ctl.acc(3'h0, 6'h38, 8'h00, 18'h3ffff);
         u_ctl.acc(3'h3, 6'h27, 8'h00, 18'h3ffff);
         rd(6'h2f, 8'h00, 18'h2aa55);
         u_ctl.acc(3'h6, 6'h1f, 8'h00, 18'h0);
         chk("ds", {data_oe_n, 18'h0}, {1'b1, 18'h0});
         rd(6'h1f, 8'hff, 18'h15ac3);
         @(negedge sys_clk) oe_n <= 1'b1;
         @(negedge sys_clk);
         chk("oe", {data_oe_n, 18'h0}, {1'b1, 18'h0});
         oe_n <= 1'b0;
         @(negedge sys_clk);
         chk("od", {data_oe_n, data_out}, {1'b0, 18'h15ac3});
         u_ctl.acc(3'h2, 6'h27, 8'h01, 18'h00001);
         repeat (2) @(negedge sys_clk);
         chk("hz", {data_oe_n, 18'h0}, {1'b1, 18'h0});
         $display("test rw done");
      end
   endtask
   task t_sleep;
      begin
         rd(6'h1f, 8'h00, 18'h2aa55);
         u_ctl.zz(1'b1);
         repeat (2) @(negedge sys_clk);
         chk("zz", {data_oe_n, in_sleep, 17'h0}, {2'h3, 17'h0});
         u_ctl.acc(3'h2, 6'h27, 8'h00, 18'h0);
         u_ctl.zz(1'b0);
         @(negedge sys_clk);
         chk("wk", {data_oe_n, in_sleep, 17'h0}, {2'h2, 17'h0});
         rd(6'h2f, 8'h00, 18'h2aa55);
         $display("test sleep done");
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", n_checks, fail_count);
         if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      {fail_count, n_checks, reset} = {32'h0, 32'h0, 1'b1};
      oe_n = 1'b0;
      repeat (8) @(negedge sys_clk);
      reset = 1'b0;
      t_rw;
      t_sleep;
      give_verdict;
   end
   initial begin
      #20000;
      fail_count = fail_count + 1;
      give_verdict;
   end
endmodule // sss_sram_tb
